// *** logic/wba_exec.v ***
// Execution unit for word moves, word exchange and byte add/subtract
`timescale 1ns/1ps
`include "wba_exec_defs.vh"

module wba_exec #(
    parameter [15:0] SADDR_BASE = 16'hFF00
) (
    input wire I_MCLK,
    input wire I_RST,
    input wire I_START,
    input wire [2:0] I_OP,
    input wire [2:0] I_MODE,
    input wire [1:0] I_RP,
    input wire [2:0] I_REG,
    input wire [15:0] I_IMM,
    input wire [7:0] I_SADDR,
    input wire [7:0] I_DISP,
    output wire O_READY,
    output wire O_BUSY,
    output wire O_DONE,
    output reg O_REJECT,
    output reg [1:0] O_LEN,
    output reg [3:0] O_CLOCKS,
    output reg O_MEM_RD,
    output reg O_MEM_WR,
    output reg [15:0] O_MEM_ADDR,
    output reg [7:0] O_MEM_WDATA,
    input wire [7:0] I_MEM_RDATA,
    output wire [15:0] O_AX,
    output wire [15:0] O_BC,
    output wire [15:0] O_DE,
    output wire [15:0] O_HL,
    output wire [2:0] O_FLAGS
);

////////////////////////////////////////////////////////////////////////////////
// Length and clock table, zero clocks marks an illegal form
function [5:0] len_clk;
    input [2:0] op;
    input [2:0] mode;
    input [1:0] rp;
    begin
        len_clk = 6'h00;
        if (op == `WBA_OP_WMOVE) begin
            case (mode)
                `WBA_WM_IMM_RP: len_clk = {`WBA_LEN_3, `WBA_CLK_6};
                `WBA_WM_SADDRP_AX: len_clk = {`WBA_LEN_2, `WBA_CLK_6};
                `WBA_WM_AX_SADDRP: len_clk = {`WBA_LEN_2, `WBA_CLK_8};
                `WBA_WM_RP_AX: len_clk = {`WBA_LEN_1, `WBA_CLK_4};
                `WBA_WM_AX_RP: begin
                    if (rp != `WBA_PAIR_AX) begin
                        len_clk = {`WBA_LEN_1, `WBA_CLK_4};
                    end
                end
                default: len_clk = 6'h00;
            endcase
        end else if (op == `WBA_OP_WXCH) begin
            len_clk = {`WBA_LEN_1, `WBA_CLK_8};
        end else if (op == `WBA_OP_ADD || op == `WBA_OP_ADD_WITH_CARRY || op == `WBA_OP_SUB) begin
            case (mode)
                `WBA_BM_IMM: len_clk = {`WBA_LEN_2, `WBA_CLK_4};
                `WBA_BM_SADDR_IMM: len_clk = {`WBA_LEN_3, `WBA_CLK_6};
                `WBA_BM_REG: len_clk = {`WBA_LEN_2, `WBA_CLK_4};
                `WBA_BM_SADDR: len_clk = {`WBA_LEN_2, `WBA_CLK_4};
                `WBA_BM_ABS: len_clk = {`WBA_LEN_3, `WBA_CLK_8};
                `WBA_BM_PTR: len_clk = {`WBA_LEN_1, `WBA_CLK_6};
                `WBA_BM_PTR_DISP: len_clk = {`WBA_LEN_2, `WBA_CLK_6};
                default: len_clk = 6'h00;
            endcase
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State
reg [7:0] regs_r [0:7];
reg [2:0] flags_r;
reg [3:0] cnt_r;
reg [2:0] op_r;
reg [2:0] mode_r;
reg [1:0] rp_r;
reg [2:0] reg_sel_r;
reg [15:0] imm_r;
reg [7:0] saddr_r;
reg [7:0] disp_r;
reg [7:0] lo_r;
reg [7:0] hi_r;
reg mem_rd_nxt;
reg mem_wr_nxt;
reg [15:0] mem_addr_nxt;
reg [7:0] mem_wdata_nxt;

wire [5:0] start_lc;
wire start_ok;
wire accept;
wire last;
wire is_byte_op;
wire is_carry_in;
wire [15:0] ptr_val;
wire [15:0] ea;
wire [7:0] alu_a;
wire [7:0] alu_b;
wire alu_cin;
wire [8:0] sum9;
wire [4:0] nib5;
wire [7:0] alu_res;
wire alu_cy;
wire alu_ac;
integer i;

assign start_lc = len_clk(I_OP, I_MODE, I_RP);
assign start_ok = (start_lc[3:0] != 4'h0);
assign O_BUSY = (cnt_r != 4'h0);
// Clock counts run in I_MCLK cycles, the CPU clock
assign last = O_BUSY && (cnt_r == O_CLOCKS - 4'h1);
assign O_DONE = last;
assign O_READY = !O_BUSY || last;
assign accept = I_START && O_READY && start_ok;

assign O_AX = {regs_r[1], regs_r[0]};
assign O_BC = {regs_r[3], regs_r[2]};
assign O_DE = {regs_r[5], regs_r[4]};
assign O_HL = {regs_r[7], regs_r[6]};
assign O_FLAGS = flags_r;

////////////////////////////////////////////////////////////////////////////////
// Operand address and arithmetic
assign is_byte_op = (op_r == `WBA_OP_ADD) || (op_r == `WBA_OP_ADD_WITH_CARRY) ||
                    (op_r == `WBA_OP_SUB);
assign is_carry_in = (op_r == `WBA_OP_ADD_WITH_CARRY);
assign ptr_val = {regs_r[7], regs_r[6]};

assign ea = (mode_r == `WBA_BM_ABS && is_byte_op) ? imm_r :
            (mode_r == `WBA_BM_PTR && is_byte_op) ? ptr_val :
            (mode_r == `WBA_BM_PTR_DISP && is_byte_op) ?
                ptr_val + {8'h00, disp_r} :
            SADDR_BASE + {8'h00, saddr_r};

assign alu_a = (mode_r == `WBA_BM_SADDR_IMM) ? lo_r : regs_r[`WBA_REG_A];
assign alu_b = (mode_r == `WBA_BM_IMM || mode_r == `WBA_BM_SADDR_IMM) ? imm_r[7:0] :
               (mode_r == `WBA_BM_REG) ? regs_r[reg_sel_r] : lo_r;
assign alu_cin = is_carry_in & flags_r[`WBA_FLAG_CY];

// Borrow comes out as bit 8 of the widened difference
assign sum9 = (op_r == `WBA_OP_SUB) ? ({1'b0, alu_a} - {1'b0, alu_b}) :
              ({1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin});
assign nib5 = (op_r == `WBA_OP_SUB) ? ({1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]}) :
              ({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin});
assign alu_res = sum9[7:0];
assign alu_cy = sum9[8];
assign alu_ac = nib5[4];

////////////////////////////////////////////////////////////////////////////////
// Memory access schedule
always @* begin
    mem_rd_nxt = 1'b0;
    mem_wr_nxt = 1'b0;
    mem_addr_nxt = ea;
    mem_wdata_nxt = 8'h00;
    if (O_BUSY && !last) begin
        case (cnt_r)
            `WBA_STEP_FIRST: begin
                if (op_r == `WBA_OP_WMOVE && mode_r == `WBA_WM_AX_SADDRP) begin
                    mem_wr_nxt = 1'b1;
                    mem_wdata_nxt = regs_r[`WBA_REG_X];
                end else if (op_r == `WBA_OP_WMOVE) begin
                    mem_rd_nxt = (mode_r == `WBA_WM_SADDRP_AX);
                end else if (is_byte_op) begin
                    mem_rd_nxt = (mode_r != `WBA_BM_IMM) && (mode_r != `WBA_BM_REG);
                end
            end
            `WBA_STEP_SECOND: begin
                mem_addr_nxt = ea + 16'h0001;
                if (op_r == `WBA_OP_WMOVE && mode_r == `WBA_WM_AX_SADDRP) begin
                    mem_wr_nxt = 1'b1;
                    mem_wdata_nxt = regs_r[`WBA_REG_A];
                end else if (op_r == `WBA_OP_WMOVE && mode_r == `WBA_WM_SADDRP_AX) begin
                    mem_rd_nxt = 1'b1;
                end
            end
            `WBA_STEP_THIRD: begin
                // Result goes back to the same short direct byte
                if (is_byte_op && mode_r == `WBA_BM_SADDR_IMM) begin
                    mem_wr_nxt = 1'b1;
                    mem_wdata_nxt = alu_res;
                end
            end
            default: mem_rd_nxt = 1'b0;
        endcase
    end
end

always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        O_MEM_RD <= 1'b0;
        O_MEM_WR <= 1'b0;
        O_MEM_ADDR <= 16'h0000;
        O_MEM_WDATA <= 8'h00;
        lo_r <= 8'h00;
        hi_r <= 8'h00;
    end else begin
        O_MEM_RD <= mem_rd_nxt;
        O_MEM_WR <= mem_wr_nxt;
        O_MEM_ADDR <= mem_addr_nxt;
        O_MEM_WDATA <= mem_wdata_nxt;
        if (O_MEM_RD && cnt_r == `WBA_STEP_SECOND) begin
            lo_r <= I_MEM_RDATA;
        end
        if (O_MEM_RD && cnt_r == `WBA_STEP_THIRD) begin
            hi_r <= I_MEM_RDATA;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer and instruction latch
always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        cnt_r <= 4'h0;
        op_r <= 3'h0;
        mode_r <= 3'h0;
        rp_r <= 2'h0;
        reg_sel_r <= 3'h0;
        imm_r <= 16'h0000;
        saddr_r <= 8'h00;
        disp_r <= 8'h00;
        O_LEN <= 2'h0;
        O_CLOCKS <= 4'h0;
        O_REJECT <= 1'b0;
    end else begin
        O_REJECT <= I_START && O_READY && !start_ok;
        if (accept) begin
            cnt_r <= `WBA_STEP_FIRST;
            op_r <= I_OP;
            mode_r <= I_MODE;
            rp_r <= I_RP;
            reg_sel_r <= I_REG;
            imm_r <= I_IMM;
            saddr_r <= I_SADDR;
            disp_r <= I_DISP;
            O_LEN <= start_lc[5:4];
            O_CLOCKS <= start_lc[3:0];
        end else if (last) begin
            cnt_r <= 4'h0;
        end else if (O_BUSY) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register and flag commit on the final clock
always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
        for (i = 0; i < 8; i = i + 1) begin
            regs_r[i] <= 8'h00;
        end
        flags_r <= `WBA_FLAGS_RST;
    end else if (last) begin
        if (op_r == `WBA_OP_WMOVE) begin
            // Word moves leave the flags alone
            case (mode_r)
                `WBA_WM_IMM_RP: begin
                    regs_r[{rp_r, 1'b0}] <= imm_r[7:0];
                    regs_r[{rp_r, 1'b1}] <= imm_r[15:8];
                end
                `WBA_WM_SADDRP_AX: begin
                    regs_r[`WBA_REG_X] <= lo_r;
                    regs_r[`WBA_REG_A] <= hi_r;
                end
                `WBA_WM_RP_AX: begin
                    regs_r[`WBA_REG_X] <= regs_r[{rp_r, 1'b0}];
                    regs_r[`WBA_REG_A] <= regs_r[{rp_r, 1'b1}];
                end
                `WBA_WM_AX_RP: begin
                    regs_r[{rp_r, 1'b0}] <= regs_r[`WBA_REG_X];
                    regs_r[{rp_r, 1'b1}] <= regs_r[`WBA_REG_A];
                end
                default: flags_r <= flags_r;
            endcase
        end else if (op_r == `WBA_OP_WXCH) begin
            regs_r[`WBA_REG_X] <= regs_r[{rp_r, 1'b0}];
            regs_r[`WBA_REG_A] <= regs_r[{rp_r, 1'b1}];
            regs_r[{rp_r, 1'b0}] <= regs_r[`WBA_REG_X];
            regs_r[{rp_r, 1'b1}] <= regs_r[`WBA_REG_A];
        end else if (is_byte_op) begin
            if (mode_r != `WBA_BM_SADDR_IMM) begin
                regs_r[`WBA_REG_A] <= alu_res;
            end
            flags_r[`WBA_FLAG_Z] <= (alu_res == 8'h00);
            flags_r[`WBA_FLAG_AC] <= alu_ac;
            flags_r[`WBA_FLAG_CY] <= alu_cy;
        end
    end
end

endmodule

// *** logic/wba_exec_defs.vh ***
// Constants for the word move and byte add/subtract execution unit
// Behaviour
// - Add immediate to accumulator: 2 bytes, 4 clocks
// - Add immediate to short direct byte: 3 bytes, 6 clocks
// - Add from absolute address: 3 bytes, 8 clocks
// - Add via pointer pair, optional displacement: 6 clocks
// - Add-with-carry immediate into short direct byte
// - Add-with-carry from short direct: 2 bytes, 4 clocks
// - Subtract immediate, borrow to carry: 2 bytes, 4 clocks
// - Subtract via pointer plus displacement: 2 bytes, 6 clocks
// - Subtract from absolute address: 3 bytes, 8 clocks
// - Move accumulator pair to pair excludes accumulator pair
// - Clock counts are cycles of the CPU clock
`ifndef WBA_EXEC_DEFS_VH
`define WBA_EXEC_DEFS_VH

// Operation classes
`define WBA_OP_WMOVE 3'h0
`define WBA_OP_WXCH 3'h1
`define WBA_OP_ADD 3'h2
`define WBA_OP_ADD_WITH_CARRY 3'h3
`define WBA_OP_SUB 3'h4

// Word move modes
`define WBA_WM_IMM_RP 3'h0
`define WBA_WM_SADDRP_AX 3'h1
`define WBA_WM_AX_SADDRP 3'h2
`define WBA_WM_RP_AX 3'h3
`define WBA_WM_AX_RP 3'h4

// Byte arithmetic modes
`define WBA_BM_IMM 3'h0
`define WBA_BM_SADDR_IMM 3'h1
`define WBA_BM_REG 3'h2
`define WBA_BM_SADDR 3'h3
`define WBA_BM_ABS 3'h4
`define WBA_BM_PTR 3'h5
`define WBA_BM_PTR_DISP 3'h6

// Register and pair indices
`define WBA_REG_X 3'h0
`define WBA_REG_A 3'h1
`define WBA_PAIR_AX 2'h0
`define WBA_PAIR_PTR 2'h3

// Flag positions in the flag output
`define WBA_FLAG_Z 2
`define WBA_FLAG_AC 1
`define WBA_FLAG_CY 0
`define WBA_FLAGS_RST 3'h0

// Instruction lengths in bytes
`define WBA_LEN_1 2'h1
`define WBA_LEN_2 2'h2
`define WBA_LEN_3 2'h3

// Instruction times in CPU clocks
`define WBA_CLK_4 4'h4
`define WBA_CLK_6 4'h6
`define WBA_CLK_8 4'h8

// Sequencer steps
`define WBA_STEP_FIRST 4'h1
`define WBA_STEP_SECOND 4'h2
`define WBA_STEP_THIRD 4'h3

`endif

// *** tb/test_wba_exec.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module test_wba_exec;
    typedef struct packed {
        logic [2:0] op;
        logic [2:0] md;
        logic [1:0] rp;
        logic [15:0] imm;
        logic [7:0] b;
        logic [15:0] ax;
        logic [2:0] fl;
        logic [1:0] ln;
        logic [3:0] ck;
    } wba_row_t;
    localparam int NR = 18;
    wba_row_t rows [0:NR-1] = '{
        '{3'h0, 3'h0, 2'h3, 16'hFF10, 8'h00, 16'h0000, 3'h0, 2'h3, 4'h6},
        '{3'h0, 3'h0, 2'h0, 16'h12F0, 8'h00, 16'h12F0, 3'h0, 2'h3, 4'h6},
        '{3'h2, 3'h0, 2'h0, 16'h00EE, 8'h00, 16'h00F0, 3'h7, 2'h2, 4'h4},
        '{3'h3, 3'h3, 2'h0, 16'h0000, 8'h20, 16'h21F0, 3'h0, 2'h2, 4'h4},
        '{3'h2, 3'h4, 2'h0, 16'h1234, 8'h00, 16'h55F0, 3'h0, 2'h3, 4'h8},
        '{3'h2, 3'h5, 2'h0, 16'h0000, 8'h00, 16'h65F0, 3'h0, 2'h1, 4'h6},
        '{3'h2, 3'h6, 2'h0, 16'h0000, 8'hF5, 16'h6AF0, 3'h0, 2'h2, 4'h6},
        '{3'h4, 3'h0, 2'h0, 16'h006B, 8'h00, 16'hFFF0, 3'h3, 2'h2, 4'h4},
        '{3'h4, 3'h6, 2'h0, 16'h0000, 8'h0F, 16'hE0F0, 3'h0, 2'h2, 4'h6},
        '{3'h4, 3'h4, 2'h0, 16'h00E0, 8'h00, 16'h00F0, 3'h4, 2'h3, 4'h8},
        '{3'h2, 3'h1, 2'h0, 16'h00D0, 8'h30, 16'h00F0, 3'h5, 2'h3, 4'h6},
        '{3'h3, 3'h1, 2'h0, 16'h000F, 8'h30, 16'h00F0, 3'h2, 2'h3, 4'h6},
        '{3'h1, 3'h0, 2'h3, 16'h0000, 8'h00, 16'hFF10, 3'h2, 2'h1, 4'h8},
        '{3'h0, 3'h4, 2'h1, 16'h0000, 8'h00, 16'hFF10, 3'h2, 2'h1, 4'h4},
        '{3'h0, 3'h2, 2'h0, 16'h0000, 8'h40, 16'hFF10, 3'h2, 2'h2, 4'h8},
        '{3'h0, 3'h3, 2'h3, 16'h0000, 8'h00, 16'h00F0, 3'h2, 2'h1, 4'h4},
        '{3'h0, 3'h1, 2'h0, 16'h0000, 8'h40, 16'hFF10, 3'h2, 2'h2, 4'h6},
        '{3'h3, 3'h3, 2'h0, 16'h0000, 8'h30, 16'h0F10, 3'h1, 2'h2, 4'h4}
    };
    wba_row_t hr;
    logic I_MCLK = 1'b0;
    logic I_RST = 1'b1;
    logic I_START = 1'b0;
    logic [2:0] I_OP = 3'h0;
    logic [2:0] I_MODE = 3'h0;
    logic [1:0] I_RP = 2'h0;
    logic [2:0] I_REG = 3'h0;
    logic [15:0] I_IMM = 16'h0000;
    logic [7:0] I_SADDR = 8'h00;
    logic [7:0] I_DISP = 8'h00;
    wire O_READY, O_BUSY, O_DONE, O_REJECT, O_MEM_RD, O_MEM_WR;
    wire [1:0] O_LEN;
    wire [3:0] O_CLOCKS;
    wire [2:0] O_FLAGS;
    wire [7:0] O_MEM_WDATA, I_MEM_RDATA;
    wire [15:0] O_MEM_ADDR, O_AX, O_BC, O_HL;
    int mismatches = 0;
    int cmp_count = 0;
    int i;
    ////////////////////////////////////////
    wba_exec dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_START(I_START), .I_OP(I_OP),
        .I_MODE(I_MODE), .I_RP(I_RP), .I_REG(I_REG), .I_IMM(I_IMM), .I_SADDR(I_SADDR),
        .I_DISP(I_DISP), .O_READY(O_READY), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
        .O_REJECT(O_REJECT), .O_LEN(O_LEN), .O_CLOCKS(O_CLOCKS), .O_MEM_RD(O_MEM_RD),
        .O_MEM_WR(O_MEM_WR), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
        .I_MEM_RDATA(I_MEM_RDATA), .O_AX(O_AX), .O_BC(O_BC), .O_DE(), .O_HL(O_HL),
        .O_FLAGS(O_FLAGS));
    wba_mem_model u_mem (.i_clk(I_MCLK), .i_rd(O_MEM_RD), .i_wr(O_MEM_WR),
        .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_rdata(I_MEM_RDATA));
    always #5 I_MCLK = ~I_MCLK;
    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic issue(input wba_row_t r);
        I_OP = r.op;
        I_MODE = r.md;
        I_RP = r.rp;
        I_REG = r.b[2:0];
        I_IMM = r.imm;
        I_SADDR = r.b;
        I_DISP = r.b;
        I_START = 1'b1;
    endtask
    // Entered in the first cycle after the accept edge
    task automatic wait_done(input wba_row_t r);
        logic [3:0] n;
        n = 4'h1;
        check(16'(O_LEN), 16'(r.ln));
        check(16'(O_CLOCKS), 16'(r.ck));
        while (O_DONE !== 1'b1 && n < 4'hC) begin
            @(negedge I_MCLK);
            n++;
        end
        check(16'(n), 16'(r.ck - 4'h1));
    endtask
    ////////////////////////////////////////
    initial begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge I_MCLK);
        I_RST = 1'b0;
        issue(rows[0]);
        // Each next row is started in the done cycle of the last
        for (i = 0; i < NR; i++) begin
            @(negedge I_MCLK);
            I_START = 1'b0;
            if (i > 0) begin
                check(O_AX, rows[i-1].ax);
                check(16'(O_FLAGS), 16'(rows[i-1].fl));
            end
            wait_done(rows[i]);
            if (i < NR - 1) issue(rows[i+1]);
        end
        @(negedge I_MCLK);
        check(O_AX, rows[NR-1].ax);
        check(O_BC, 16'hFF10);
        check(O_HL, 16'h00F0);
        issue(wba_row_t'{3'h0, 3'h4, 2'h0, 16'h0000, 8'h00, 16'h0000, 3'h0, 2'h1, 4'h4});
        @(negedge I_MCLK);
        I_START = 1'b0;
        check(16'({O_REJECT, O_BUSY}), 16'h0002);
        @(negedge I_MCLK);
        check(O_AX, 16'h0F10);
        issue(rows[2]);
        @(negedge I_MCLK);
        I_START = 1'b0;
        I_RST = 1'b1;
        @(negedge I_MCLK);
        check(O_AX, 16'h0000);
        check(16'({O_READY, O_BUSY, O_DONE, O_FLAGS}), 16'h0020);
        I_RST = 1'b0;
        hr = '{3'h2, 3'h0, 2'h0, 16'h0080, 8'h00, 16'h8000, 3'h0, 2'h2, 4'h4};
        issue(hr);
        @(negedge I_MCLK);
        I_START = 1'b0;
        wait_done(hr);
        @(negedge I_MCLK);
        check(O_AX, hr.ax);
        tally_and_finish;
    end
endmodule

// *** tb/wba_exec_checker.sv ***
// Timing and flag checks for the execution unit
`timescale 1ns/1ps
module wba_exec_checker #(
    parameter [15:0] SADDR_BASE = 16'hFF00
) (
    input wire I_MCLK,
    input wire I_RST,
    input wire I_START,
    input wire [2:0] I_OP,
    input wire [2:0] I_MODE,
    input wire [1:0] I_RP,
    input wire [7:0] I_SADDR,
    input wire O_READY,
    input wire O_DONE,
    input wire O_REJECT,
    input wire [1:0] O_LEN,
    input wire [3:0] O_CLOCKS,
    input wire O_MEM_WR,
    input wire [15:0] O_MEM_ADDR,
    input wire [15:0] O_AX,
    input wire [2:0] O_FLAGS
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    ////////////////////////////////////////
    sequence s_go(logic [2:0] op, logic [2:0] md);
        I_START && O_READY && I_OP == op && I_MODE == md;
    endsequence
    sequence s_shape(logic [1:0] ln, logic [3:0] ck);
        O_LEN == ln && O_CLOCKS == ck;
    endsequence
    // Result write-back to the short direct byte
    sequence s_wb(logic [7:0] a);
        s_shape(2'h3, 4'h6) ##3 O_MEM_WR && O_MEM_ADDR == SADDR_BASE + a ##1 O_DONE;
    endsequence
    ////////////////////////////////////////
    property p_add_imm;
        s_go(3'h2, 3'h0) |=> s_shape(2'h2, 4'h4) ##2 O_DONE;
    endproperty
    property p_add_simm;
        logic [7:0] a;
        (s_go(3'h2, 3'h1), a = I_SADDR) |=> s_wb(a);
    endproperty
    property p_add_with_carry_simm;
        logic [7:0] a;
        (s_go(3'h3, 3'h1), a = I_SADDR) |=> s_wb(a);
    endproperty
    property p_add_abs;
        s_go(3'h2, 3'h4) |=> s_shape(2'h3, 4'h8) ##6 O_DONE;
    endproperty
    property p_add_ptr;
        s_go(3'h2, 3'h5) |=> s_shape(2'h1, 4'h6) ##4 O_DONE;
    endproperty
    property p_sub_disp;
        s_go(3'h4, 3'h6) |=> s_shape(2'h2, 4'h6) ##4 O_DONE;
    endproperty
    property p_no_ax_dest;
        s_go(3'h0, 3'h4) ##0 I_RP == 2'h0 |=> O_REJECT && $stable(O_AX);
    endproperty
    property p_wmove_flags;
        s_go(3'h0, 3'h2) |=> s_shape(2'h2, 4'h8) ##0 $stable(O_FLAGS) [*8];
    endproperty
    property p_xch;
        s_go(3'h1, 3'h0) |=> s_shape(2'h1, 4'h8) ##6 O_DONE;
    endproperty
    ////////////////////////////////////////
    a_add_imm: assert property (p_add_imm) else $error("add imm timing");
    a_add_simm: assert property (p_add_simm) else $error("add saddr wb");
    a_add_with_carry_simm: assert property (p_add_with_carry_simm) else $error("add_with_carry saddr wb");
    a_add_abs: assert property (p_add_abs) else $error("add abs timing");
    a_add_ptr: assert property (p_add_ptr) else $error("add ptr timing");
    a_sub_disp: assert property (p_sub_disp) else $error("sub disp timing");
    a_no_ax_dest: assert property (p_no_ax_dest) else $error("bad dest taken");
    a_wmove_flags: assert property (p_wmove_flags) else $error("flags moved");
    a_xch: assert property (p_xch) else $error("exchange timing");
endmodule

bind wba_exec wba_exec_checker #(.SADDR_BASE(SADDR_BASE)) u_chk (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_START(I_START), .I_OP(I_OP),
    .I_MODE(I_MODE), .I_RP(I_RP), .I_SADDR(I_SADDR), .O_READY(O_READY),
    .O_DONE(O_DONE), .O_REJECT(O_REJECT), .O_LEN(O_LEN), .O_CLOCKS(O_CLOCKS),
    .O_MEM_WR(O_MEM_WR), .O_MEM_ADDR(O_MEM_ADDR), .O_AX(O_AX), .O_FLAGS(O_FLAGS)
);

// *** tb/wba_mem_model.sv ***
// Data memory model facing the execution unit
`timescale 1ns/1ps
module wba_mem_model (
    input wire i_clk,
    input wire i_rd,
    input wire i_wr,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    output wire [7:0] o_rdata
);
    reg [7:0] mem [0:65535];
    reg [7:0] last_r;
    integer k;
    initial begin
        for (k = 0; k < 65536; k = k + 1) mem[k] = k[7:0];
        last_r = 8'h00;
    end
    // Write at the edge ending the strobe cycle
    always @(posedge i_clk) begin
        if (i_wr) mem[i_addr] <= i_wdata;
        if (i_rd) last_r <= mem[i_addr];
    end
    // Idle bus shows the inverse of the last read
    assign o_rdata = i_rd ? mem[i_addr] : ~last_r;
endmodule
